//--- inc/tpm_defs.svh
// register offsets, field positions and reset values of the motor pwm unit
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TPM_A_CTRL 8'h00
`define TPM_A_PPSC 8'h04
`define TPM_A_TPSC 8'h08
`define TPM_A_PER 8'h0C
`define TPM_A_CU 8'h10
`define TPM_A_CV 8'h14
`define TPM_A_CW 8'h18
`define TPM_A_REP 8'h1C
`define TPM_A_DT 8'h20
`define TPM_A_POL 8'h24
`define TPM_A_TCMP 8'h28
`define TPM_A_TCAP 8'h2C
`define TPM_A_PEND 8'h30
`define TPM_A_IEN 8'h34
`define TPM_A_STAT 8'h38
// ----------------------------------------
// control register fields
// ----------------------------------------
`define TPM_C_PWMEN 0
`define TPM_C_MODE 1
`define TPM_C_DTEN 2
`define TPM_C_TACEN 3
`define TPM_C_CLRCAP 4
`define TPM_C_RISE 5
`define TPM_C_FALL 6
`define TPM_C_ESTEN 7
`define TPM_C_OE 8
// ----------------------------------------
// pending and enable bits, index = priority; estop bit 8 is pending only, with no enable bit or priority
// ----------------------------------------
`define TPM_I_XFER 0
`define TPM_I_ZERO 1
`define TPM_I_PER 2
`define TPM_I_CAP 3
`define TPM_I_CU 4
`define TPM_I_CV 5
`define TPM_I_CW 6
`define TPM_I_OVF 7
`define TPM_I_EST 8
// ----------------------------------------
// reset values
// ----------------------------------------
`define TPM_RST_CTRL 9'h000
`define TPM_RST_TCMP 8'hFF
`define TPM_RST_ZERO 32'h0000_0000
`endif

//--- inc/tpm_pkg.sv
// types shared by the motor pwm unit
package tpm_pkg;
	typedef enum logic {TPM_DOWN, TPM_UP} tpm_dir_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [8:0] ctrl;
		logic [7:0] ppsc;
		logic [11:0] tpsc;
		logic [9:0] per_pre;
		logic [10:0] cu_pre;
		logic [10:0] cv_pre;
		logic [10:0] cw_pre;
		logic [7:0] rep;
		logic [5:0] dt;
		logic [5:0] pol;
		logic [7:0] tcmp;
		logic [15:0] tcap;
		logic [8:0] pend;
		logic [7:0] ien;
		logic [7:0] pcnt;
		logic [11:0] tpcnt;
		logic [9:0] cnt;
		tpm_dir_t dir;
		logic [7:0] rep_cnt;
		logic [9:0] per;
		logic [10:0] cu;
		logic [10:0] cv;
		logic [10:0] cw;
		logic [2:0] ph;
		logic [15:0] tcnt;
		logic tprev;
		logic en_prev;
		logic half;
		logic [5:0] pins;
		logic [2:0] vec;
		logic any;
	} tpm_state_t;
endpackage

//--- rtl/tpm_deadtime.sv
// dead-time generator for one phase: delayed high and low side outputs
`timescale 1ns/1ps
`default_nettype none
module tpm_deadtime #(
	parameter int DT_W = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic dt_enable,
	input wire logic [DT_W-1:0] dt_value,
	input wire logic phase_in,
	output logic high_out,
	output logic low_out
);
	if (DT_W != 6) begin : g_chk
		$error("tpm_deadtime serves a 6-bit dead time only");
	end

	typedef struct packed {
		logic prev;
		logic [DT_W-1:0] cnt;
		logic h;
		logic l;
	} tpm_dt_t;

	tpm_dt_t s_reg;
	tpm_dt_t s_next;

	// ----------------------------------------
	// delay logic
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.prev = phase_in;
		if (!dt_enable) begin
			s_next.h = phase_in;
			s_next.l = ~phase_in;
			s_next.cnt = '0;
		end else if (phase_in != s_reg.prev) begin
			// both sides off at once: the rising side waits the dead time
			s_next.h = 1'b0;
			s_next.l = 1'b0;
			s_next.cnt = dt_value;
			if (dt_value == '0) begin
				s_next.h = phase_in;
				s_next.l = ~phase_in;
			end
		end else if (s_reg.cnt != '0) begin
			// a phase edge inside the wait restarts it, so a short pulse
			// never appears at all
			if (tick) begin
				s_next.cnt = s_reg.cnt - 1'b1;
				if (s_reg.cnt == {{(DT_W-1){1'b0}}, 1'b1}) begin
					s_next.h = phase_in;
					s_next.l = ~phase_in;
				end
			end
		end else begin
			s_next.h = phase_in;
			s_next.l = ~phase_in;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign high_out = s_reg.h;
	assign low_out = s_reg.l;
endmodule
`default_nettype wire

//--- rtl/tpm_top.sv
// three-phase motor pwm unit with tacho capture and wishbone registers
// Behaviour
// - enabled tacho edge captures count, may clear it, raises capture event
// - tacho count clocked from pwm clock, 12-bit prescaler, divide 1..4096
// - counter high byte reaching tacho compare raises overflow event
// - pwm counter ticks through 8-bit prescaler, divide 1..256
// - centre mode counts up to period, down to zero, up again
// - classical mode counts up to period, clears, counts up again
// - centre mode: phase low at up match, high at down match
// - phase compare uses counter zero-extended to 11 bits
// - compare above period holds phase high, compare zero holds it low
// - classical mode: phase low at match, high when counter clears
// - preloads copied to active compares at counter zero with repeat zero
// - transfers happen once every N pwm cycles, N from 1 to 256
// - high side follows phase with delayed rising edge
// - low side is inverted phase with delayed rising edge
// - dead time disabled means no added delay
// - pulse shorter than dead time is suppressed
// - each of six outputs individually inverted by polarity bits
// - eight interrupt requests plus emergency-stop request
// - fixed priority: transfer, zero, period, capture, U, V, W, overflow
// - emergency stop disables motor outputs and requests an interrupt
// - pending bits set only when enabled; cleared only by software
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defs.svh"
module tpm_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tacho_in,
	input wire logic estop_in,
	output logic phase_u_high_pin,
	output logic phase_u_low_pin,
	output logic phase_v_high_pin,
	output logic phase_v_low_pin,
	output logic phase_w_high_pin,
	output logic phase_w_low_pin,
	output logic pins_oe,
	output logic [7:0] irq_req,
	output logic [2:0] irq_vector,
	output logic irq_any,
	output logic irq_estop
);
	tpm_pkg::tpm_state_t s_reg;
	tpm_pkg::tpm_state_t s_next;

	logic [2:0] dt_h;
	logic [2:0] dt_l;
	logic [10:0] cmp [3];
	logic [5:0] dtv;

	// ----------------------------------------
	// byte-lane merge for partial writes
	// ----------------------------------------
	function automatic logic [31:0] wmerge(
		input logic [31:0] o,
		input logic [31:0] d,
		input logic [3:0] sl
	);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sl[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// phase level from the live counter, direction and active compare
	function automatic logic phase_lvl(
		input logic [10:0] c,
		input logic [9:0] cnt,
		input logic [9:0] per,
		input logic centre,
		input logic down
	);
		logic r;
		r = 1'b0;
		if (c == 11'h000) begin
			r = 1'b0;
		end else if (c > {1'b0, per}) begin
			r = 1'b1;
		end else if (centre && down) begin
			r = ({1'b0, cnt} <= c);
		end else begin
			r = ({1'b0, cnt} < c);
		end
		return r;
	endfunction

	// ----------------------------------------
	// dead-time generators
	// ----------------------------------------
	assign cmp[0] = s_reg.cu;
	assign cmp[1] = s_reg.cv;
	assign cmp[2] = s_reg.cw;
	assign dtv = s_reg.dt;

	for (genvar g = 0; g < 3; g++) begin : g_dt
		tpm_deadtime #(
			.DT_W(6)
		) u_dt (
			.clk(clk),
			.resetn(resetn),
			.tick(s_reg.half),
			.dt_enable(s_reg.ctrl[`TPM_C_DTEN]),
			.dt_value(dtv),
			.phase_in(s_reg.ph[g]),
			.high_out(dt_h[g]),
			.low_out(dt_l[g])
		);
	end

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	logic acc;
	logic wr;
	logic [31:0] rd;
	logic [31:0] m;
	logic [8:0] clr;
	logic [8:0] set;
	logic en;
	logic ptick;
	logic ttick;
	logic step;
	logic [9:0] cn;
	logic xfer;
	logic cap;
	logic est;
	logic [15:0] inc;
	logic [5:0] raw;

	always_comb begin
		s_next = s_reg;
		acc = wb_cyc_i & wb_stb_i & ~s_reg.ack;
		wr = acc & wb_we_i;
		set = '0;
		clr = '0;
		cn = s_reg.cnt;
		inc = s_reg.tcnt + 16'h0001;
		raw = '0;
		// read view; also the old value for byte-lane merging
		unique case (wb_adr_i)
			`TPM_A_CTRL: rd = {23'h0, s_reg.ctrl};
			`TPM_A_PPSC: rd = {24'h0, s_reg.ppsc};
			`TPM_A_TPSC: rd = {20'h0, s_reg.tpsc};
			`TPM_A_PER: rd = {22'h0, s_reg.per_pre};
			`TPM_A_CU: rd = {21'h0, s_reg.cu_pre};
			`TPM_A_CV: rd = {21'h0, s_reg.cv_pre};
			`TPM_A_CW: rd = {21'h0, s_reg.cw_pre};
			`TPM_A_REP: rd = {24'h0, s_reg.rep};
			`TPM_A_DT: rd = {26'h0, s_reg.dt};
			`TPM_A_POL: rd = {26'h0, s_reg.pol};
			`TPM_A_TCMP: rd = {24'h0, s_reg.tcmp};
			`TPM_A_TCAP: rd = {16'h0, s_reg.tcap};
			`TPM_A_PEND: rd = {23'h0, s_reg.pend};
			`TPM_A_IEN: rd = {24'h0, s_reg.ien};
			`TPM_A_STAT: rd = {15'h0, s_reg.dir, 6'h0, s_reg.cnt};
			default: rd = `TPM_RST_ZERO;
		endcase
		m = wmerge(rd, wb_dat_i, wb_sel_i);
		s_next.ack = acc;
		if (acc) begin
			s_next.rdat = rd;
		end
		if (wr) begin
			unique case (wb_adr_i)
				`TPM_A_CTRL: s_next.ctrl = m[8:0];
				`TPM_A_PPSC: s_next.ppsc = m[7:0];
				`TPM_A_TPSC: s_next.tpsc = m[11:0];
				`TPM_A_PER: s_next.per_pre = m[9:0];
				`TPM_A_CU: s_next.cu_pre = m[10:0];
				`TPM_A_CV: s_next.cv_pre = m[10:0];
				`TPM_A_CW: s_next.cw_pre = m[10:0];
				`TPM_A_REP: s_next.rep = m[7:0];
				`TPM_A_DT: s_next.dt = m[5:0];
				`TPM_A_POL: s_next.pol = m[5:0];
				`TPM_A_TCMP: s_next.tcmp = m[7:0];
				`TPM_A_PEND: clr = wb_dat_i[8:0] & {wb_sel_i[1], {8{wb_sel_i[0]}}};
				`TPM_A_IEN: s_next.ien = m[7:0];
				default: ;
			endcase
		end

		// pwm prescaler and counter
		en = s_reg.ctrl[`TPM_C_PWMEN];
		ptick = en && (s_reg.pcnt == s_reg.ppsc);
		step = ptick;
		s_next.pcnt = (!en || ptick) ? 8'h00 : s_reg.pcnt + 8'h01;
		if (!en) begin
			s_next.cnt = '0;
			s_next.dir = tpm_pkg::TPM_UP;
		end else if (step) begin
			if (!s_reg.ctrl[`TPM_C_MODE]) begin
				cn = (s_reg.cnt >= s_reg.per) ? 10'h000 : s_reg.cnt + 10'h001;
			end else if (s_reg.dir == tpm_pkg::TPM_UP) begin
				if (s_reg.cnt >= s_reg.per) begin
					cn = (s_reg.cnt == 10'h000) ? 10'h000 : s_reg.cnt - 10'h001;
					s_next.dir = (cn == 10'h000) ? tpm_pkg::TPM_UP : tpm_pkg::TPM_DOWN;
				end else begin
					cn = s_reg.cnt + 10'h001;
				end
			end else begin
				cn = s_reg.cnt - 10'h001;
				if (cn == 10'h000) begin
					s_next.dir = tpm_pkg::TPM_UP;
				end
			end
			s_next.cnt = cn;
		end

		// compare events on the step that reaches the value
		set[`TPM_I_ZERO] = step && (cn == 10'h000);
		set[`TPM_I_PER] = step && (cn == s_reg.per);
		set[`TPM_I_CU] = step && ({1'b0, cn} == s_reg.cu);
		set[`TPM_I_CV] = step && ({1'b0, cn} == s_reg.cv);
		set[`TPM_I_CW] = step && ({1'b0, cn} == s_reg.cw);

		// preload transfer; the enabling edge loads once as well
		s_next.en_prev = en;
		xfer = (en && !s_reg.en_prev) ||
			(step && cn == 10'h000 && s_reg.rep_cnt == 8'h00);
		if (!en) begin
			s_next.rep_cnt = 8'h00;
		end else if (xfer) begin
			s_next.rep_cnt = s_reg.rep;
			s_next.per = s_reg.per_pre;
			s_next.cu = s_reg.cu_pre;
			s_next.cv = s_reg.cv_pre;
			s_next.cw = s_reg.cw_pre;
		end else if (step && cn == 10'h000) begin
			s_next.rep_cnt = s_reg.rep_cnt - 8'h01;
		end
		set[`TPM_I_XFER] = xfer;

		// phase levels
		for (int p = 0; p < 3; p++) begin
			s_next.ph[p] = phase_lvl(cmp[p], s_reg.cnt, s_reg.per,
				s_reg.ctrl[`TPM_C_MODE], s_reg.dir == tpm_pkg::TPM_DOWN);
		end

		// tacho prescaler, counter and capture
		ttick = ptick && (s_reg.tpcnt == s_reg.tpsc);
		if (!en) begin
			s_next.tpcnt = 12'h000;
		end else if (ptick) begin
			s_next.tpcnt = ttick ? 12'h000 : s_reg.tpcnt + 12'h001;
		end
		s_next.tprev = tacho_in;
		cap = s_reg.ctrl[`TPM_C_TACEN] &&
			((tacho_in && !s_reg.tprev && s_reg.ctrl[`TPM_C_RISE]) ||
			(!tacho_in && s_reg.tprev && s_reg.ctrl[`TPM_C_FALL]));
		if (s_reg.ctrl[`TPM_C_TACEN] && ttick) begin
			// reaching the compare also restarts the count
			if (inc[15:8] == s_reg.tcmp && s_reg.tcnt[15:8] != s_reg.tcmp) begin
				set[`TPM_I_OVF] = 1'b1;
				s_next.tcnt = 16'h0000;
			end else begin
				s_next.tcnt = inc;
			end
		end
		if (cap) begin
			s_next.tcap = s_reg.tcnt;
			if (s_reg.ctrl[`TPM_C_CLRCAP]) begin
				s_next.tcnt = 16'h0000;
			end
		end
		set[`TPM_I_CAP] = cap;

		// emergency stop: hardware clear of output enable beats software
		est = estop_in && s_reg.ctrl[`TPM_C_ESTEN];
		if (est) begin
			s_next.ctrl[`TPM_C_OE] = 1'b0;
		end
		set[7:0] = set[7:0] & s_reg.ien;
		set[`TPM_I_EST] = est;
		// stop pending cannot be cleared while the input still stands
		clr[`TPM_I_EST] = clr[`TPM_I_EST] & ~estop_in;
		s_next.pend = (s_reg.pend & ~clr) | set;

		// fixed priority, lowest index wins
		s_next.any = |s_next.pend[7:0];
		s_next.vec = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (s_next.pend[i]) begin
				s_next.vec = 3'(i);
			end
		end

		// pins
		s_next.half = ~s_reg.half;
		for (int p = 0; p < 3; p++) begin
			raw[2*p] = dt_h[p];
			raw[2*p+1] = dt_l[p];
		end
		s_next.pins = (raw ^ s_reg.pol) & {6{s_next.ctrl[`TPM_C_OE]}};
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
			s_reg.ctrl <= `TPM_RST_CTRL;
			s_reg.tcmp <= `TPM_RST_TCMP;
			s_reg.dir <= tpm_pkg::TPM_UP;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdat;
	assign phase_u_high_pin = s_reg.pins[0];
	assign phase_u_low_pin = s_reg.pins[1];
	assign phase_v_high_pin = s_reg.pins[2];
	assign phase_v_low_pin = s_reg.pins[3];
	assign phase_w_high_pin = s_reg.pins[4];
	assign phase_w_low_pin = s_reg.pins[5];
	assign pins_oe = s_reg.ctrl[`TPM_C_OE];
	assign irq_req = s_reg.pend[7:0];
	assign irq_vector = s_reg.vec;
	assign irq_any = s_reg.any;
	assign irq_estop = s_reg.pend[`TPM_I_EST];
endmodule
`default_nettype wire

//--- tb/test_tpm_top.sv
// self-checking testbench of the motor pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defs.svh"
module test_tpm_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic estop = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [15:0] half = 16'h0000;
	logic [31:0] rd, dato;
	logic ack, tacho, oe, iany, iest;
	logic [7:0] ireq;
	logic [2:0] ivec;
	wire logic [5:0] pins;
	int shoot, t0;
	int errors = 0;
	int n_compared = 0;
	int ncyc = 0;
	int hi [6];
	always #12.5 clk = ~clk;
	always @(posedge clk) ncyc <= ncyc + 1;
	tpm_top dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dato), .wb_ack_o(ack), .tacho_in(tacho), .estop_in(estop),
		.phase_u_high_pin(pins[0]), .phase_u_low_pin(pins[1]),
		.phase_v_high_pin(pins[2]), .phase_v_low_pin(pins[3]),
		.phase_w_high_pin(pins[4]), .phase_w_low_pin(pins[5]), .pins_oe(oe),
		.irq_req(ireq), .irq_vector(ivec), .irq_any(iany), .irq_estop(iest));
	tpm_bridge_model br_u (.clk(clk), .resetn(resetn), .pins(pins),
		.pins_oe(oe), .half(half), .tacho(tacho), .shoot(shoot));
	task automatic report_and_stop();
		$display("compared %0d wrong %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %0h seen %0h", s, e, g);
			errors++;
		end
	endtask
	task automatic fail_wait();
		errors++;
		report_and_stop();
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// ack is looked at mid-cycle, then taken at the next rising edge
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) fail_wait();
		@(posedge clk);
		rd = dato;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wait_irq(input int b, input int lim);
		int i;
		for (i = 0; i < lim && ireq[b] !== 1'b1; i++) @(negedge clk);
		if (i == lim) fail_wait();
	endtask
	task automatic measure(input int n);
		hi = '{default: 0};
		repeat (n) begin
			@(negedge clk);
			for (int k = 0; k < 6; k++) hi[k] += int'(pins[k]);
		end
	endtask
	// period fixed at 7; disabling first makes the enable edge load compares
	task automatic pwm(input logic [31:0] c, p, u, v, w, dt, pol);
		wb(1'b1, `TPM_A_CTRL, 32'h0);
		wb(1'b1, `TPM_A_PPSC, p);
		wb(1'b1, `TPM_A_PER, 32'h7);
		wb(1'b1, `TPM_A_CU, u);
		wb(1'b1, `TPM_A_CV, v);
		wb(1'b1, `TPM_A_CW, w);
		wb(1'b1, `TPM_A_DT, dt);
		wb(1'b1, `TPM_A_POL, pol);
		wb(1'b1, `TPM_A_CTRL, c);
		repeat (40) @(posedge clk);
	endtask
	task automatic t_regs();
		wb(1'b0, `TPM_A_TCMP, 32'h0);
		check("tcmp reset", 32'hFF, rd);
		wb(1'b1, 8'h3C, 32'h5A5A);
		wb(1'b0, 8'h3C, 32'h0);
		check("unmapped", 32'h0, rd);
		$display("test registers done");
	endtask
	task automatic t_wave();
		pwm(32'h101, 32'h1, 32'h3, 32'h0, 32'h9, 32'h0, 32'h0);
		measure(160);
		check("classic u high", 32'h3C, hi[0]);
		check("classic u low", 32'h64, hi[1]);
		check("v held low", 32'h0, hi[2]);
		check("w held high", 32'hA0, hi[4]);
		pwm(32'h103, 32'h0, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0);
		measure(140);
		check("centre u high", 32'h3C, hi[0]);
		pwm(32'h101, 32'h0, 32'h3, 32'h3, 32'h3, 32'h0, 32'h1);
		measure(80);
		check("inverted u high", 32'h32, hi[0]);
		check("plain u low", 32'h32, hi[1]);
		check("plain v high", 32'h1E, hi[2]);
		$display("test waveforms done");
	endtask
	task automatic t_dead();
		pwm(32'h105, 32'h0, 32'h5, 32'h5, 32'h5, 32'h1, 32'h0);
		// inverted polarity earlier made both sides high on purpose
		t0 = shoot;
		measure(80);
		check("short dead", 32'h1, hi[0] > 0 && hi[0] < 50);
		check("same delay", 32'h1, hi[2] == hi[0] && hi[4] == hi[0]);
		check("no overlap", 32'h0, shoot - t0);
		wb(1'b1, `TPM_A_DT, 32'h4);
		repeat (20) @(posedge clk);
		measure(80);
		check("high swallowed", 32'h0, hi[0]);
		check("low swallowed", 32'h0, hi[1]);
		$display("test dead time done");
	endtask
	task automatic t_repeat();
		pwm(32'h101, 32'h0, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0);
		wb(1'b1, `TPM_A_REP, 32'h2);
		wb(1'b1, `TPM_A_PEND, 32'h1FF);
		repeat (50) @(posedge clk);
		wb(1'b0, `TPM_A_PEND, 32'h0);
		check("masked pending", 32'h0, rd);
		wb(1'b1, `TPM_A_IEN, 32'h1);
		wait_irq(0, 100);
		wb(1'b1, `TPM_A_PEND, 32'h1);
		wait_irq(0, 100);
		t0 = ncyc;
		wb(1'b1, `TPM_A_PEND, 32'h1);
		wait_irq(0, 100);
		check("transfer spacing", 32'h18, ncyc - t0);
		wb(1'b1, `TPM_A_IEN, 32'hFF);
		repeat (60) @(posedge clk);
		wb(1'b1, `TPM_A_IEN, 32'hFE);
		wb(1'b1, `TPM_A_PEND, 32'h1);
		@(negedge clk);
		check("vector", 32'h1, ivec);
		check("any request", 32'h1, iany);
		$display("test repetition done");
	endtask
	task automatic t_tacho();
		logic [31:0] ctl [3] = '{32'h139, 32'h159, 32'h179};
		logic [31:0] tp [3] = '{32'h0, 32'h1, 32'h0};
		logic [31:0] ex [3] = '{32'h64, 32'h32, 32'h32};
		@(posedge clk);
		half <= 16'h0032;
		for (int r = 0; r < 3; r++) begin
			wb(1'b1, `TPM_A_CTRL, 32'h0);
			wb(1'b1, `TPM_A_TPSC, tp[r]);
			wb(1'b1, `TPM_A_IEN, 32'h8);
			wb(1'b1, `TPM_A_PEND, 32'hFF);
			wb(1'b1, `TPM_A_CTRL, ctl[r]);
			wait_irq(3, 300);
			wb(1'b1, `TPM_A_PEND, 32'h8);
			wait_irq(3, 300);
			wb(1'b0, `TPM_A_TCAP, 32'h0);
			check("capture", 32'h1, rd + 2 >= ex[r] && rd <= ex[r] + 2);
		end
		@(posedge clk);
		half <= 16'h0000;
		wb(1'b1, `TPM_A_CTRL, 32'h0);
		wb(1'b1, `TPM_A_TPSC, 32'h0);
		wb(1'b1, `TPM_A_TCMP, 32'h1);
		wb(1'b1, `TPM_A_IEN, 32'h80);
		wb(1'b1, `TPM_A_PEND, 32'hFF);
		wb(1'b1, `TPM_A_CTRL, 32'h109);
		// the count starts from a leftover; the first event zeroes it
		wait_irq(7, 400);
		wb(1'b1, `TPM_A_PEND, 32'h80);
		t0 = ncyc;
		wait_irq(7, 400);
		check("overflow", 32'h1, ncyc - t0 >= 250 && ncyc - t0 <= 262);
		$display("test tacho done");
	endtask
	task automatic t_estop();
		pwm(32'h181, 32'h0, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0);
		@(posedge clk);
		estop <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("oe after stop", 32'h0, oe);
		check("stop pending", 32'h1, iest);
		wb(1'b1, `TPM_A_PEND, 32'h100);
		repeat (2) @(posedge clk);
		#1;
		check("stop held", 32'h1, iest);
		@(posedge clk);
		estop <= 1'b0;
		wb(1'b1, `TPM_A_PEND, 32'h100);
		repeat (3) @(posedge clk);
		#1;
		check("stop cleared", 32'h0, iest);
		$display("test stop done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_wave();
		t_dead();
		t_repeat();
		t_tacho();
		t_estop();
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- tb/tpm_bridge_model.sv
// power bridge and tachogenerator seen by the motor pwm unit
`timescale 1ns/1ps
`default_nettype none
module tpm_bridge_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [5:0] pins,
	input wire logic pins_oe,
	input wire logic [15:0] half,
	output logic tacho,
	output int shoot
);
	int n;
	// tacho stands still while half is zero, so no edge sneaks in
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tacho <= 1'b0;
			n <= 0;
			shoot <= 0;
		end else begin
			if ((pins & (pins >> 1) & 6'h15) != 6'h00 && pins_oe) begin
				shoot <= shoot + 1;
			end
			if (half != 16'h0000) begin
				n <= (n + 1 >= half) ? 0 : n + 1;
				if (n + 1 >= half) begin
					tacho <= ~tacho;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tpm_monitor.sv
// concurrent checks on the ports of the motor pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defs.svh"
module tpm_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic estop_in,
	input wire logic phase_u_high_pin,
	input wire logic phase_u_low_pin,
	input wire logic phase_v_high_pin,
	input wire logic phase_v_low_pin,
	input wire logic phase_w_high_pin,
	input wire logic phase_w_low_pin,
	input wire logic pins_oe,
	input wire logic [7:0] irq_req,
	input wire logic [2:0] irq_vector,
	input wire logic irq_any,
	input wire logic irq_estop
);
	wire logic pw = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `TPM_A_PEND;
	wire logic [5:0] pins = {phase_w_low_pin, phase_w_high_pin,
		phase_v_low_pin, phase_v_high_pin, phase_u_low_pin, phase_u_high_pin};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_any_or: assert property (irq_any == (|irq_req))
		else $error("irq_any wrong");
	a_vector_prio: assert property (irq_any |-> irq_req[irq_vector] &&
		(irq_req & ((8'h01 << irq_vector) - 8'h01)) == 8'h00)
		else $error("vector not highest priority");
	a_idle_vector: assert property (!irq_any |-> irq_vector == 3'h0)
		else $error("vector not zero when idle");
	a_pins_off: assert property (!pins_oe |-> pins == 6'h00)
		else $error("pins driven while released");
	a_estop_off: assert property ($rose(irq_estop) |-> ##[0:2] !pins_oe)
		else $error("outputs not disabled by stop");
	a_estop_hold: assert property (estop_in && irq_estop |=> irq_estop)
		else $error("stop pending cleared while active");
	a_pend_sticky: assert property (|($past(irq_req) & ~irq_req) |->
		$past(pw) || $past(pw, 2) || $past(pw, 3))
		else $error("pending cleared without write");
endmodule
bind tpm_top tpm_monitor mon_u (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_ack_o, .estop_in, .phase_u_high_pin,
	.phase_u_low_pin, .phase_v_high_pin, .phase_v_low_pin, .phase_w_high_pin,
	.phase_w_low_pin, .pins_oe, .irq_req, .irq_vector, .irq_any, .irq_estop);
`default_nettype wire
